// ===== include/fcb_map.vh
`ifndef FCB_MAP_VH
`define FCB_MAP_VH
// controller register byte offsets (axi4-lite, one word each)
`define FCB_REG_CTRL 8'h00
`define FCB_REG_ADDR 8'h04
`define FCB_REG_WDATA 8'h08
`define FCB_REG_STAT 8'h0c
`define FCB_REG_RDATA 8'h10
`define FCB_REG_PINS 8'h14
// ctrl field positions
`define FCB_CTRL_GO_BIT 0
`define FCB_CTRL_OP_LSB 4
`define FCB_CTRL_OP_MSB 7
`define FCB_CTRL_PD_BIT 8
`define FCB_CTRL_VHH_BIT 9
// operation codes
`define FCB_OP_READ 4'h0
`define FCB_OP_CMD 4'h1
`define FCB_OP_TWO 4'h2
`define FCB_OP_PDOWN 4'h3
// status bits
`define FCB_ST_BUSY_BIT 0
`define FCB_ST_RDY_BIT 1
`define FCB_ST_ERR_BIT 2
// device command codes
`define FCB_CMD_READ_ARRAY 8'hff
`define FCB_CMD_READ_ID 8'h90
`define FCB_CMD_READ_STATUS 8'h70
`define FCB_CMD_CLEAR_STATUS 8'h50
`define FCB_CMD_ERASE_SETUP 8'h20
`define FCB_CMD_CONFIRM 8'hd0
`define FCB_CMD_WRITE_SETUP 8'h40
`define FCB_CMD_WRITE_ALT 8'h10
`define FCB_CMD_SUSPEND 8'hb0
`define FCB_CMD_LOCK_SETUP 8'h60
`define FCB_CMD_LOCK_BLOCK 8'h01
`define FCB_CMD_LOCK_MASTER 8'hf1
// identifier addresses
`define FCB_ID_MFR 20'h00000
`define FCB_ID_DEV 20'h00001
`define FCB_ID_BLOCK_LOCK 16'h0002
`define FCB_ID_MASTER 20'h00003
`define FCB_STATUS_RESET 8'h80
// timing, in ns and in 5 ns cycles (rounded up)
`define FCB_CLK_NS 5
`define FCB_T_PDOWN_NS 100
`define FCB_PDOWN_CYC ((`FCB_T_PDOWN_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_T_STROBE_NS 50
`define FCB_STROBE_CYC ((`FCB_T_STROBE_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_T_WAKE_NS 1000
`define FCB_WAKE_CYC ((`FCB_T_WAKE_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_T_ACCESS_NS 150
`define FCB_ACCESS_CYC ((`FCB_T_ACCESS_NS + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`endif

// ===== design/fcb_pin_sync.v
`timescale 1ns/1ps
`include "fcb_map.vh"
// three-stage synchroniser per bit; a change is taken once stages two and three agree
module fcb_pin_sync #(
	parameter W = 10
) (
	input wire i_mclk,
	input wire i_nrst,
	input wire i_ce,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			reg out_ff;
			// s1 feeds only s2, so metastability stays in one stage
			always @(posedge i_mclk) begin
				if (!i_nrst) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					out_ff <= 1'b0;
				end else if (i_ce) begin
					s1_ff <= i_async[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						out_ff <= s3_ff;
				end
			end
			assign o_sync[g] = out_ff;
		end
	endgenerate
endmodule // fcb_pin_sync

// ===== design/fcb_host_ctrl.v
`timescale 1ns/1ps
`include "fcb_map.vh"
// Overview of operation
// - read needs select, output enable, strobe high
// - power-down pin held low 100 ns minimum on a power-down order; after reset it rises one cycle after reset ends
// - host waits wake time before commands, reads
// - erase is 20 then d0 same block
// - host never lowers output and write together
module fcb_host_ctrl #(
	parameter AW = 20,
	parameter PDOWN_CYC = `FCB_PDOWN_CYC,
	parameter STROBE_CYC = `FCB_STROBE_CYC,
	parameter WAKE_CYC = `FCB_WAKE_CYC,
	parameter ACCESS_CYC = `FCB_ACCESS_CYC
) (
	input wire i_mclk,
	input wire i_nrst,
	input wire i_ce,
	// axi4-lite slave
	input wire [7:0] i_awaddr,
	input wire i_awvalid,
	output wire o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output wire o_wready,
	output reg [1:0] o_bresp,
	output reg o_bvalid,
	input wire i_bready,
	input wire [7:0] i_araddr,
	input wire i_arvalid,
	output wire o_arready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp,
	output reg o_rvalid,
	input wire i_rready,
	// flash pins
	output reg [AW-1:0] o_addr,
	output reg o_chip_select_n,
	output reg o_output_enable_n,
	output reg o_write_strobe_n,
	output reg o_reset_powerdown_n,
	output reg o_reset_vhh,
	input wire [7:0] i_data_lines,
	output reg [7:0] o_data_lines,
	output reg o_data_lines_oe,
	input wire i_ready_busy_n
);
	localparam CW = 16;
	localparam [CW-1:0] PD_C = PDOWN_CYC[CW-1:0];
	localparam [CW-1:0] ST_C = STROBE_CYC[CW-1:0];
	localparam [CW-1:0] WK_C = WAKE_CYC[CW-1:0];
	localparam [CW-1:0] AC_C = ACCESS_CYC[CW-1:0];
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_WSET = 7'h02;
	localparam [6:0] S_WLOW = 7'h04;
	localparam [6:0] S_WREL = 7'h08;
	localparam [6:0] S_RLOW = 7'h10;
	localparam [6:0] S_PDN = 7'h20;
	localparam [6:0] S_WAKE = 7'h40;

	reg [6:0] st_ff;
	reg [CW-1:0] cnt_ff;
	reg [AW-1:0] addr_ff;
	reg [15:0] wdata_ff;
	reg [3:0] op_ff;
	reg second_ff;
	reg busy_ff;
	reg err_ff;
	reg pd_hold_ff;
	reg vhh_ff;
	reg [7:0] rdata_ff;
	reg aw_ok_ff;
	reg w_ok_ff;
	reg [7:0] awaddr_ff;
	reg [31:0] wd_ff;
	reg [3:0] wstrb_ff;
	wire [8:0] sync_out;
	wire rb_n_s;
	wire [7:0] din_s;
	wire go_wr;
	wire [7:0] cur_byte;

	// pins from the flash cross in through four flops: three sync stages and an output flop
	fcb_pin_sync #(.W(9)) u_sync (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_async({i_ready_busy_n, i_data_lines}),
		.o_sync(sync_out)
	);
	assign rb_n_s = sync_out[8];
	assign din_s = sync_out[7:0];

	// address and data may arrive in either order; both held until the write completes
	assign o_awready = i_ce && !aw_ok_ff && !o_bvalid;
	assign o_wready = i_ce && !w_ok_ff && !o_bvalid;
	assign o_arready = i_ce && !o_rvalid;
	assign go_wr = aw_ok_ff && w_ok_ff && !o_bvalid;
	assign cur_byte = second_ff ? wdata_ff[15:8] : wdata_ff[7:0];

	// bus write path and register file
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wd_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'b00;
			addr_ff <= {AW{1'b0}};
			wdata_ff <= 16'h0000;
			op_ff <= `FCB_OP_READ;
			pd_hold_ff <= 1'b0;
			vhh_ff <= 1'b0;
		end else if (i_ce) begin
			if (i_awvalid && o_awready) begin
				aw_ok_ff <= 1'b1;
				awaddr_ff <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_ok_ff <= 1'b1;
				wd_ff <= i_wdata;
				wstrb_ff <= i_wstrb;
			end
			if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
			if (go_wr) begin
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= 2'b00;
				case (awaddr_ff)
					`FCB_REG_ADDR: begin
						if (wstrb_ff[0])
							addr_ff <= wd_ff[AW-1:0];
					end
					`FCB_REG_WDATA: begin
						if (wstrb_ff[0])
							wdata_ff[7:0] <= wd_ff[7:0];
						if (wstrb_ff[1])
							wdata_ff[15:8] <= wd_ff[15:8];
					end
					`FCB_REG_CTRL: begin
						// a new order while one runs is answered slverr
						if (busy_ff && wd_ff[`FCB_CTRL_GO_BIT])
							o_bresp <= 2'b10;
						else if (wstrb_ff[0])
							op_ff <= wd_ff[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB];
						if (wstrb_ff[1]) begin
							pd_hold_ff <= wd_ff[`FCB_CTRL_PD_BIT];
							vhh_ff <= wd_ff[`FCB_CTRL_VHH_BIT];
						end
					end
					`FCB_REG_STAT, `FCB_REG_RDATA, `FCB_REG_PINS: o_bresp <= 2'b00;
					default: o_bresp <= 2'b10;
				endcase
			end
		end
	end

	// bus read path
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= 2'b00;
		end else if (i_ce) begin
			if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp <= 2'b00;
				case (i_araddr)
					`FCB_REG_CTRL: o_rdata <= {22'h0, vhh_ff, pd_hold_ff, op_ff, 4'h0};
					`FCB_REG_ADDR: o_rdata <= {{(32-AW){1'b0}}, addr_ff};
					`FCB_REG_WDATA: o_rdata <= {16'h0000, wdata_ff};
					`FCB_REG_STAT: o_rdata <= {29'h0, err_ff, rb_n_s, busy_ff};
					`FCB_REG_RDATA: o_rdata <= {24'h000000, rdata_ff};
					`FCB_REG_PINS: o_rdata <= {31'h0, o_reset_powerdown_n};
					default: begin
						o_rdata <= 32'h0000_0000;
						o_rresp <= 2'b10;
					end
				endcase
			end
		end
	end

	// pin sequencer; strobes are held a whole strobe time each phase
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			st_ff <= S_IDLE;
			cnt_ff <= {CW{1'b0}};
			second_ff <= 1'b0;
			busy_ff <= 1'b0;
			err_ff <= 1'b0;
			rdata_ff <= 8'h00;
			o_addr <= {AW{1'b0}};
			o_chip_select_n <= 1'b1;
			o_output_enable_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_reset_powerdown_n <= 1'b0;
			o_reset_vhh <= 1'b0;
			o_data_lines <= 8'h00;
			o_data_lines_oe <= 1'b0;
		end else if (i_ce) begin
			o_reset_vhh <= vhh_ff;
			if (go_wr && awaddr_ff == `FCB_REG_CTRL && wd_ff[`FCB_CTRL_GO_BIT] &&
				wstrb_ff[0] && !busy_ff)
				err_ff <= 1'b0;
			case (st_ff)
				S_IDLE: begin
					o_chip_select_n <= 1'b1;
					o_output_enable_n <= 1'b1;
					o_write_strobe_n <= 1'b1;
					o_data_lines_oe <= 1'b0;
					cnt_ff <= {CW{1'b0}};
					if (!o_reset_powerdown_n) begin
						// leaving power-down or reset: wake before any cycle
						if (!pd_hold_ff) begin
							o_reset_powerdown_n <= 1'b1;
							busy_ff <= 1'b1;
							st_ff <= S_WAKE;
						end
					end else if (go_wr && awaddr_ff == `FCB_REG_CTRL &&
						wd_ff[`FCB_CTRL_GO_BIT] && wstrb_ff[0]) begin
						busy_ff <= 1'b1;
						second_ff <= 1'b0;
						o_addr <= addr_ff;
						case (wd_ff[`FCB_CTRL_OP_MSB:`FCB_CTRL_OP_LSB])
							`FCB_OP_READ: st_ff <= S_RLOW;
							`FCB_OP_CMD, `FCB_OP_TWO: st_ff <= S_WSET;
							`FCB_OP_PDOWN: begin
								o_reset_powerdown_n <= 1'b0;
								st_ff <= S_PDN;
							end
							default: begin
								busy_ff <= 1'b0;
								err_ff <= 1'b1;
							end
						endcase
					end
				end
				S_WSET: begin
					// data lines driven and output enable high on the same edge the strobe falls
					o_output_enable_n <= 1'b1;
					o_data_lines <= cur_byte;
					o_data_lines_oe <= 1'b1;
					o_chip_select_n <= 1'b0;
					o_write_strobe_n <= 1'b0;
					cnt_ff <= {CW{1'b0}};
					st_ff <= S_WLOW;
				end
				S_WLOW: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff + 1'b1 >= ST_C) begin
						// write strobe rises first, so it alone latches the data
						o_write_strobe_n <= 1'b1;
						cnt_ff <= {CW{1'b0}};
						st_ff <= S_WREL;
					end
				end
				S_WREL: begin
					o_chip_select_n <= 1'b1;
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff + 1'b1 >= ST_C) begin
						o_data_lines_oe <= 1'b0;
						cnt_ff <= {CW{1'b0}};
						// two-cycle orders: erase, byte write, lock use the high byte next
						if (op_ff == `FCB_OP_TWO && !second_ff) begin
							second_ff <= 1'b1;
							st_ff <= S_WSET;
						end else begin
							busy_ff <= 1'b0;
							st_ff <= S_IDLE;
						end
					end
				end
				S_RLOW: begin
					// write strobe stays high through the read
					o_write_strobe_n <= 1'b1;
					o_data_lines_oe <= 1'b0;
					o_chip_select_n <= 1'b0;
					o_output_enable_n <= 1'b0;
					cnt_ff <= cnt_ff + 1'b1;
					// wait access time plus three sync flops
					if (cnt_ff >= AC_C + 16'd3) begin
						rdata_ff <= din_s;
						o_chip_select_n <= 1'b1;
						o_output_enable_n <= 1'b1;
						busy_ff <= 1'b0;
						st_ff <= S_IDLE;
					end
				end
				S_PDN: begin
					cnt_ff <= cnt_ff + 1'b1;
					// minimum low time, then stay down while software holds it
					if (cnt_ff + 1'b1 >= PD_C) begin
						busy_ff <= !pd_hold_ff; // no idle gap before wake, a go cannot slip in
						st_ff <= S_IDLE;
					end
				end
				S_WAKE: begin
					cnt_ff <= cnt_ff + 1'b1;
					// wake time covers both the command and the output recovery
					if (cnt_ff + 1'b1 >= WK_C && cnt_ff + 1'b1 >= AC_C) begin
						busy_ff <= 1'b0;
						st_ff <= S_IDLE;
					end
				end
				default: st_ff <= S_IDLE;
			endcase
		end
	end
endmodule // fcb_host_ctrl

// ===== dv/fcb_host_ctrl_properties.sv
`timescale 1ns/1ps
module fcb_host_ctrl_chk #(
	parameter AW = 20,
	parameter PDOWN_CYC = 20,
	parameter WAKE_CYC = 200
) (
	input wire i_mclk,
	input wire i_nrst,
	input wire [AW-1:0] o_addr,
	input wire o_chip_select_n,
	input wire o_output_enable_n,
	input wire o_write_strobe_n,
	input wire o_reset_powerdown_n,
	input wire o_data_lines_oe
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	logic [7:0] pd_cnt_ff;
	logic [15:0] wk_cnt_ff;
	// low time and wake time of the reset pin; reset saturates so release never fires
	always @(posedge i_mclk) begin
		if (!i_nrst)
			pd_cnt_ff <= 8'hff;
		else if (o_reset_powerdown_n)
			pd_cnt_ff <= 8'h00;
		else if (pd_cnt_ff != 8'hff)
			pd_cnt_ff <= pd_cnt_ff + 8'h01;
		if (!o_reset_powerdown_n)
			wk_cnt_ff <= 16'h0000;
		else if (wk_cnt_ff != 16'hffff)
			wk_cnt_ff <= wk_cnt_ff + 16'h0001;
	end
	sequence s_wr_low;
		!o_write_strobe_n && !o_chip_select_n && o_data_lines_oe && o_output_enable_n;
	endsequence
	property p_rd_pins;
		$fell(o_output_enable_n) |-> !o_chip_select_n && o_write_strobe_n && o_reset_powerdown_n;
	endproperty
	property p_no_oe_we;
		!o_output_enable_n |-> o_write_strobe_n && !o_data_lines_oe;
	endproperty
	property p_pd_hold;
		$rose(o_reset_powerdown_n) |-> pd_cnt_ff >= PDOWN_CYC;
	endproperty
	property p_wake;
		$fell(o_chip_select_n) |-> wk_cnt_ff >= WAKE_CYC;
	endproperty
	property p_wr_pulse;
		$fell(o_write_strobe_n) |-> s_wr_low [*2];
	endproperty
	property p_addr_hold;
		!o_chip_select_n && $past(!o_chip_select_n) |-> $stable(o_addr);
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("read without proper pins");
	a_no_oe_we: assert property (p_no_oe_we) else $error("output and write low together");
	a_pd_hold: assert property (p_pd_hold) else $error("power-down pulse too short");
	a_wake: assert property (p_wake) else $error("select before wake time");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse malformed");
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
endmodule // fcb_host_ctrl_chk
bind fcb_host_ctrl fcb_host_ctrl_chk #(.AW(AW), .PDOWN_CYC(PDOWN_CYC), .WAKE_CYC(WAKE_CYC))
	i_fcb_host_ctrl_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_addr(o_addr),
	.o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
	.o_write_strobe_n(o_write_strobe_n), .o_reset_powerdown_n(o_reset_powerdown_n),
	.o_data_lines_oe(o_data_lines_oe));

// ===== dv/fcb_flash_model.sv
`timescale 1ns/1ps
module fcb_flash_model #(
	parameter [7:0] MFR = 8'h5a
) (
	input wire [19:0] i_addr,
	input wire i_chip_select_n,
	input wire i_output_enable_n,
	input wire i_write_strobe_n,
	input wire i_reset_powerdown_n,
	input wire i_reset_vhh,
	input wire [7:0] i_dq,
	output wire [7:0] o_dq,
	output wire o_dq_oe,
	output logic o_ready_busy_n = 1'b1
);
	logic [7:0] mem [int];
	logic [15:0] lock = 16'h0000;
	logic master = 1'b0;
	logic [1:0] mode = 2'd0;
	logic [7:0] pend = 8'h00;
	logic [7:0] stat = 8'h80;
	event ev_run;
	// oe is an argument only so the value refreshes on every read strobe
	function automatic [7:0] rdv(input [19:0] a, input oe, input [1:0] m);
		if (m == 2'd2)
			return stat;
		if (m == 2'd0)
			return mem.exists(a) ? mem[a] : 8'hff;
		if (a == 20'h0)
			return MFR;
		if (a == 20'h3)
			return {7'h0, master};
		return (a[15:0] == 16'h2) ? {7'h0, lock[a[19:16]]} : 8'h00;
	endfunction
	assign o_dq = rdv(i_addr, i_output_enable_n, mode);
	assign o_dq_oe = !i_chip_select_n && !i_output_enable_n && i_write_strobe_n
		&& i_reset_powerdown_n;
	// the later strobe sees both high and is skipped
	always @(posedge i_write_strobe_n or posedge i_chip_select_n) begin
		if (i_reset_powerdown_n && (i_write_strobe_n ^ i_chip_select_n)) begin
			if (pend == 8'h00) begin
				case (i_dq)
				8'hff: mode = 2'd0;
				8'h90: mode = 2'd1;
				8'h70: mode = 2'd2;
				8'h50: stat = 8'h80;
				8'h20, 8'h40, 8'h10, 8'h60: pend = i_dq;
				default: ;
				endcase
			end else begin
				mode = 2'd2;
				if (pend == 8'h60 && i_dq == 8'h01 && (!master || i_reset_vhh))
					lock[i_addr[19:16]] = 1'b1;
				if (pend == 8'h60 && i_dq == 8'hf1 && i_reset_vhh)
					master = 1'b1;
				if (pend == 8'h60 && i_dq == 8'hd0 && (!master || i_reset_vhh))
					lock = 16'h0000;
				if (pend != 8'h60 && pend != 8'h20 && (!lock[i_addr[19:16]] || i_reset_vhh))
					mem[i_addr] = i_dq;
				pend = 8'h00;
				->ev_run;
			end
		end
	end
	// deep power-down returns the front end to array reads
	always @(negedge i_reset_powerdown_n) begin
		mode = 2'd0;
		pend = 8'h00;
		stat = 8'h80;
	end
	// sequencer time is fixed; long enough to be seen through the synchroniser
	always @(ev_run) begin
		o_ready_busy_n = 1'b0;
		#200;
		o_ready_busy_n = 1'b1;
	end
endmodule // fcb_flash_model

// ===== dv/fcb_host_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "fcb_map.vh"
module fcb_host_ctrl_tb_top;
	localparam [7:0] MFR = 8'h5a; // arbitrary maker code
	logic i_mclk = 0, i_nrst = 0, awvalid = 0, wvalid = 0, arvalid = 0;
	logic bready = 0, rready = 0, ce = 1, vhh_req = 0;
	logic [3:0] wstrb = 4'hf;
	logic [7:0] awaddr = 0, araddr = 0, bus_q = 0;
	logic [31:0] wdata = 0, rd;
	logic [1:0] resp;
	int errors = 0, checks_done = 0, cyc = 0;
	wire awready, wready, bvalid, arready, rvalid, cs_n, oe_n, we_n, rp_n, vhh, c_oe, f_oe, rb_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [19:0] addr;
	wire [7:0] c_dq, f_dq;
	// a released bus shows the inverse of its last level
	wire [7:0] dq = f_oe ? f_dq : c_oe ? c_dq : ~bus_q;
	always @(dq) if (f_oe || c_oe) bus_q = dq;
	always #2.5 i_mclk = ~i_mclk;
	fcb_host_ctrl #(.PDOWN_CYC(20), .STROBE_CYC(2), .WAKE_CYC(4), .ACCESS_CYC(2)) i_fcb_host_ctrl (
		.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_addr(addr),
		.o_chip_select_n(cs_n), .o_output_enable_n(oe_n), .o_write_strobe_n(we_n),
		.o_reset_powerdown_n(rp_n), .o_reset_vhh(vhh), .i_data_lines(dq),
		.o_data_lines(c_dq), .o_data_lines_oe(c_oe), .i_ready_busy_n(rb_n));
	fcb_flash_model #(.MFR(MFR)) i_fcb_flash_model (.i_addr(addr), .i_chip_select_n(cs_n),
		.i_output_enable_n(oe_n), .i_write_strobe_n(we_n), .i_reset_powerdown_n(rp_n),
		.i_reset_vhh(vhh), .i_dq(dq), .o_dq(f_dq), .o_dq_oe(f_oe), .o_ready_busy_n(rb_n));
	task automatic stop_test;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input [31:0] g, input [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// address and data offered together, each dropped when taken
	task automatic axi_wr(input [7:0] a, input [31:0] d);
		@(posedge i_mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge i_mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge i_mclk); while (bvalid !== 1'b1);
		bready <= 0;
		resp = bresp;
	endtask
	task automatic axi_rd(input [7:0] a);
		@(posedge i_mclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge i_mclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge i_mclk); while (rvalid !== 1'b1);
		rready <= 0;
		rd = rdata;
		resp = rresp;
	endtask
	task automatic idle(input bit rdy);
		do axi_rd(`FCB_REG_STAT); while (rd[0] !== 1'b0 || (rdy && rd[1] !== 1'b1));
	endtask
	task automatic run(input [3:0] op, input [19:0] a, input [15:0] d, input bit rdy);
		axi_wr(`FCB_REG_ADDR, {12'h0, a});
		axi_wr(`FCB_REG_WDATA, {16'h0, d});
		axi_wr(`FCB_REG_CTRL, {22'h0, vhh_req, 1'b0, op, 4'h1});
		idle(rdy);
	endtask
	task automatic rd_at(input [19:0] a, input [7:0] e);
		run(`FCB_OP_READ, a, 16'h0, 1);
		axi_rd(`FCB_REG_RDATA);
		chk(rd[7:0], e);
	endtask
	task automatic t_map;
		axi_rd(8'h40);
		chk(rd, 32'h0);
		chk(resp, 2'b10);
		// byte lanes: only the strobed lane of the second write lands
		axi_wr(`FCB_REG_WDATA, 32'h0000_1234);
		wstrb <= 4'h1;
		axi_wr(`FCB_REG_WDATA, 32'h0000_abcd);
		wstrb <= 4'hf;
		axi_rd(`FCB_REG_WDATA);
		chk(rd, 32'h0000_12cd);
		axi_rd(`FCB_REG_PINS);
		chk(rd[0], 1'b1);
	endtask
	task automatic t_ident;
		run(`FCB_OP_CMD, 20'h0, 16'h0090, 1);
		rd_at(20'h00000, MFR);
		rd_at(20'h00003, 8'h00);
	endtask
	task automatic t_lock;
		run(`FCB_OP_TWO, 20'h30000, 16'h0160, 0);
		// the synchronised ready pin lags the busy flag, so look one poll later
		axi_rd(`FCB_REG_STAT);
		chk(rd[1], 1'b0);
		idle(1);
		run(`FCB_OP_CMD, 20'h0, 16'h0090, 1);
		rd_at(20'h30002, 8'h01);
		rd_at(20'h20002, 8'h00);
	endtask
	task automatic t_write;
		for (int i = 0; i < 2; i++)
			run(`FCB_OP_TWO, 20'h10005 + i, {8'h5a + 8'(i), i ? 8'h10 : 8'h40}, 1);
		run(`FCB_OP_TWO, 20'h30001, 16'h3340, 1);
		run(`FCB_OP_CMD, 20'h0, 16'h00ff, 1);
		rd_at(20'h10005, 8'h5a);
		rd_at(20'h10006, 8'h5b);
		rd_at(20'h30001, 8'hff);
	endtask
	// high-voltage level lets a locked block be written
	task automatic t_vhh;
		vhh_req = 1;
		run(`FCB_OP_TWO, 20'h30001, 16'h4440, 1);
		chk(vhh, 1'b1);
		vhh_req = 0;
		run(`FCB_OP_CMD, 20'h0, 16'h00ff, 1);
		rd_at(20'h30001, 8'h44);
	endtask
	// clock enable low in mid-read freezes the bus and the pins
	task automatic t_freeze;
		axi_wr(`FCB_REG_ADDR, 32'h0001_0006);
		axi_wr(`FCB_REG_CTRL, {24'h0, `FCB_OP_READ, 4'h1});
		ce <= 1'b0;
		repeat (8) @(posedge i_mclk);
		chk({29'h0, awready, wready, arready}, 32'h0);
		ce <= 1'b1;
		idle(1);
		axi_rd(`FCB_REG_RDATA);
		chk(rd[7:0], 8'h5b);
	endtask
	task automatic t_pdown;
		run(`FCB_OP_CMD, 20'h0, 16'h0070, 1);
		axi_wr(`FCB_REG_CTRL, {24'h0, `FCB_OP_PDOWN, 4'h1});
		axi_wr(`FCB_REG_CTRL, 32'h1);
		chk(resp, 2'b10);
		idle(1);
		rd_at(20'h10005, 8'h5a);
	endtask
	initial begin
		repeat (3) @(posedge i_mclk);
		i_nrst <= 1;
		idle(1);
		t_map;
		t_ident;
		t_lock;
		t_write;
		t_vhh;
		t_freeze;
		t_pdown;
		stop_test;
	end
	// cut a hang short
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test;
		end
	end
endmodule // fcb_host_ctrl_tb_top
